// ### logic/spisc_pkg.sv
// spisc_pkg: constants for the clock-stop serial port block
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus
package spisc_pkg;
   // time base: core period and the half-period unit H
   localparam int CORE_PERIOD_NS = 10;
   localparam int H_NS = CORE_PERIOD_NS / 2;
   localparam int TWO_H_CYC = (2 * H_NS) / CORE_PERIOD_NS;
   // word and divider widths
   localparam int WORD_W = 8;
   localparam int DIV_W = 8;
   localparam int CNT_W = 10;
   localparam logic [DIV_W-1:0] MIN_MASTER_DIV = 8'h05;
   localparam logic [DIV_W-1:0] SLAVE_DIV = 8'h01;
   localparam logic [4:0] LAST_EDGE = 5'h10;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // clock stop modes
   localparam logic [1:0] STOP_NO_DELAY = 2'h2;
   localparam logic [1:0] STOP_HALF_DELAY = 2'h3;
   // register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_TXDATA = 4'h4;
   localparam logic [3:0] ADDR_RXDATA = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;
   // control field positions
   localparam int CTL_EN = 0;
   localparam int CTL_STOP_LO = 1;
   localparam int CTL_CLK_POL = 3;
   localparam int CTL_TX_SPOL = 4;
   localparam int CTL_RX_SPOL = 5;
   localparam int CTL_TX_CDIR = 6;
   localparam int CTL_TX_SDIR = 7;
   localparam int CTL_RX_CDIR = 8;
   localparam int CTL_RX_SDIR = 9;
   localparam int CTL_SRC_SEL = 10;
   localparam int CTL_DIV_LO = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int STS_OVR = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {SPISC_IDLE, SPISC_LEAD, SPISC_RUN, SPISC_LAG} spisc_state_t;
endpackage

// ### logic/spisc_sync.sv
// spisc_sync: two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to core_clk
`timescale 1ns/10ps
module spisc_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;
   // first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ### logic/spisc_buf2.sv
// spisc_buf2: two-entry buffer with valid/ready on both sides
// assumes source and sink share core_clk
`timescale 1ns/10ps
module spisc_buf2 #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   // occupancy flags
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
   // pointers and storage
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) rd_ptr <= ~rd_ptr;
         count <= 2'(count + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule

// ### logic/spisc_top.sv
// spisc_top: clock-stop serial port, master or slave, with AXI4-Lite registers
// assumes pin inputs asynchronous; the bench resolves the two-way pins from the enables
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module spisc_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ser_tx_clock_pin_in,
   output logic ser_tx_clock_pin_out,
   output logic ser_tx_clock_pin_oe,
   input wire logic tx_frame_sync_pin_in,
   output logic tx_frame_sync_pin_out,
   output logic tx_frame_sync_pin_oe,
   input wire logic rx_frame_sync_pin,
   output logic ser_tx_data_pin_out,
   output logic ser_tx_data_pin_oe,
   input wire logic ser_rx_data_pin
);
   import spisc_pkg::*;

   logic [31:0] ctrl;
   logic overrun;
   logic [3:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic w_held;
   spisc_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [4:0] edge_cnt;
   logic sclk;
   logic fs_act;
   logic m_oe;
   logic [WORD_W-1:0] tx_sr;
   logic [WORD_W-1:0] rx_sr;
   logic [3:0] bit_cnt;
   logic first;
   logic rx_push;
   logic [WORD_W-1:0] rx_word;
   logic slv_prev_clk;
   logic slv_prev_frame;
   logic slv_oe;
   logic [3:0] pin_s;

   // control fields
   wire enable = ctrl[CTL_EN];
   wire [1:0] clock_stop_mode = ctrl[CTL_STOP_LO +: 2];
   wire tx_clock_polarity = ctrl[CTL_CLK_POL];
   wire tx_sync_polarity = ctrl[CTL_TX_SPOL];
   wire rx_sync_polarity = ctrl[CTL_RX_SPOL];
   wire tx_clock_dir = ctrl[CTL_TX_CDIR];
   wire tx_sync_dir = ctrl[CTL_TX_SDIR];
   wire rx_clock_dir = ctrl[CTL_RX_CDIR];
   wire rx_sync_dir = ctrl[CTL_RX_SDIR];
   wire sample_clock_source_sel = ctrl[CTL_SRC_SEL];
   wire [DIV_W-1:0] sample_clock_divider = ctrl[CTL_DIV_LO +: DIV_W];
   wire mode_ok = (clock_stop_mode == STOP_NO_DELAY) | (clock_stop_mode == STOP_HALF_DELAY);
   wire mode11 = (clock_stop_mode == STOP_HALF_DELAY);
   wire master_role = tx_clock_dir & tx_sync_dir & ~rx_clock_dir & ~rx_sync_dir;
   wire slave_role = ~tx_clock_dir & ~tx_sync_dir & ~rx_clock_dir & ~rx_sync_dir;
   // slave sample clock at half rate
   wire slave_clk_ok = sample_clock_source_sel & (sample_clock_divider == SLAVE_DIV);

   // pin synchronisers: clock, tx sync, rx sync, rx data
   spisc_sync #(.W(4)) u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .async_in({ser_tx_clock_pin_in, tx_frame_sync_pin_in, rx_frame_sync_pin, ser_rx_data_pin}),
      .sync_out(pin_s)
   );
   wire s_clk = pin_s[3];
   wire s_rxd = pin_s[0];
   wire s_frame_tx = tx_sync_polarity ? ~pin_s[2] : pin_s[2];
   wire s_frame_rx = rx_sync_polarity ? ~pin_s[1] : pin_s[1];

   // period in core cycles; short dividers raised to the master minimum
   wire [DIV_W-1:0] div_eff = (sample_clock_divider < MIN_MASTER_DIV) ? MIN_MASTER_DIV : sample_clock_divider;
   wire [CNT_W-1:0] period = CNT_W'((div_eff + 9'h001) * TWO_H_CYC);
   wire [CNT_W-1:0] low_w = CNT_W'(((div_eff + 9'h001) >> 1) * TWO_H_CYC);
   wire [CNT_W-1:0] high_w = CNT_W'(period - low_w);
   wire [CNT_W-1:0] idle_w = tx_clock_polarity ? high_w : low_w;
   wire [CNT_W-1:0] act_w = tx_clock_polarity ? low_w : high_w;
   wire [CNT_W-1:0] lead_len = mode11 ? period : idle_w;
   wire [CNT_W-1:0] lag_len = mode11 ? idle_w : period;

   // buffers: bus to shifter, shifter to bus
   logic tx_in_ready;
   logic tx_valid;
   logic [WORD_W-1:0] tx_word;
   logic rx_in_ready;
   logic rx_valid;
   logic [WORD_W-1:0] rx_data;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_tx = (aw_addr == ADDR_TXDATA);
   wire wr_go = aw_held & w_held & ~s_axi_bvalid & (~wr_tx | tx_in_ready);
   wire w_data_lane0 = 1'b1;
   wire tx_push = wr_go & wr_tx & w_data_lane0;
   wire rd_rx = ar_take & (s_axi_araddr == ADDR_RXDATA);

   // master start and frame start events
   wire m_go = enable & master_role & mode_ok & (state == SPISC_IDLE) & tx_valid & rx_in_ready;
   wire s_start = enable & slave_role & slave_clk_ok & s_frame_tx & ~slv_prev_frame;
   wire frame_start = m_go | s_start;
   wire tx_pop = frame_start & tx_valid;
   spisc_buf2 #(.W(WORD_W)) u_txbuf (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_valid(tx_push),
      .in_ready(tx_in_ready),
      .in_data(w_data[WORD_W-1:0]),
      .out_valid(tx_valid),
      .out_ready(tx_pop),
      .out_data(tx_word)
   );
   spisc_buf2 #(.W(WORD_W)) u_rxbuf (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .in_data(rx_word),
      .out_valid(rx_valid),
      .out_ready(rd_rx),
      .out_data(rx_data)
   );

   // master clock phases
   wire phase_end = (state == SPISC_RUN) & (cnt == '0);
   wire to_idle = phase_end & (sclk != tx_clock_polarity);
   wire m_lead = ((state == SPISC_LEAD) & (cnt == '0)) | (phase_end & ~to_idle);
   wire m_trail = to_idle;
   wire last_edge = to_idle & (edge_cnt == LAST_EDGE - 5'h01);
   // slave clock edges seen on the synchronised pin
   wire s_active = enable & slave_role & slave_clk_ok & s_frame_tx & slv_prev_frame;
   wire s_lead = s_active & (slv_prev_clk == tx_clock_polarity) & (s_clk != tx_clock_polarity);
   wire s_trail = s_active & (slv_prev_clk != tx_clock_polarity) & (s_clk == tx_clock_polarity);
   wire lead_ev = m_lead | s_lead;
   wire trail_ev = m_trail | s_trail;
   // sample on leading edges in 11b, change on trailing edges
   wire sample_ev = mode11 ? lead_ev : trail_ev;
   wire shift_ev = mode11 ? trail_ev : (lead_ev & ~first);
   wire rx_bit = master_role ? pin_s[0] : s_rxd;
   wire [CNT_W-1:0] next_cnt = phase_end ? (to_idle ? idle_w - 1'b1 : act_w - 1'b1) : cnt - 1'b1;

   // master sequencer: lead, clocked bits, lag
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state <= SPISC_IDLE;
         cnt <= '0;
         edge_cnt <= '0;
         sclk <= 1'b0;
         fs_act <= 1'b0;
      end else begin
         case (state)
            SPISC_IDLE: begin
               // idle clock level; enable inactive until m_go starts a frame
               sclk <= tx_clock_polarity;
               fs_act <= m_go;
               cnt <= lead_len - 1'b1;
               edge_cnt <= '0;
               if (m_go) state <= SPISC_LEAD;
            end
            SPISC_LEAD: begin
               cnt <= (cnt == '0) ? act_w - 1'b1 : cnt - 1'b1;
               if (cnt == '0) begin
                  sclk <= ~sclk;
                  edge_cnt <= 5'h01;
                  state <= SPISC_RUN;
               end
            end
            SPISC_RUN: begin
               cnt <= last_edge ? lag_len - 1'b1 : next_cnt;
               if (phase_end) begin
                  sclk <= ~sclk;
                  edge_cnt <= 5'(edge_cnt + 5'h01);
               end
               if (last_edge) state <= SPISC_LAG;
            end
            SPISC_LAG: begin
               cnt <= cnt - 1'b1;
               // release the enable after the lag
               if (cnt == '0) begin
                  fs_act <= 1'b0;
                  state <= SPISC_IDLE;
               end
            end
            default: state <= SPISC_IDLE;
         endcase
      end
   end

   // master data enable: off at the last edge in 11b, one idle phase later in 10b
   wire next_m_oe = (state == SPISC_LEAD) | ((state == SPISC_RUN) & ~(last_edge & mode11))
      | ((state == SPISC_LAG) & ~mode11 & ({1'b0, cnt} + {1'b0, idle_w} > {1'b0, lag_len}));
   always_ff @(posedge core_clk) begin
      if (!reset_n) m_oe <= 1'b0;
      else m_oe <= m_go | (next_m_oe & ~(state == SPISC_IDLE));
   end

   // slave enable and clock history, slave data enable follows its enable
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         slv_prev_clk <= 1'b0;
         slv_prev_frame <= 1'b0;
         slv_oe <= 1'b0;
      end else begin
         slv_prev_clk <= s_clk;
         slv_prev_frame <= s_frame_tx & enable & slave_role & slave_clk_ok;
         slv_oe <= s_frame_tx & enable & slave_role & slave_clk_ok;
      end
   end

   // shared shifter for both roles
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         tx_sr <= '0;
         rx_sr <= '0;
         bit_cnt <= '0;
         first <= 1'b0;
         rx_push <= 1'b0;
         rx_word <= '0;
      end else begin
         rx_push <= sample_ev & (bit_cnt == LAST_BIT);
         if (frame_start) begin
            tx_sr <= tx_valid ? tx_word : '0;
            bit_cnt <= '0;
            first <= 1'b1;
         end else begin
            if (lead_ev) first <= 1'b0;
            if (shift_ev) tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
            if (sample_ev) begin
               rx_sr <= {rx_sr[WORD_W-2:0], rx_bit};
               bit_cnt <= 4'(bit_cnt + 4'h1);
               if (bit_cnt == LAST_BIT) rx_word <= {rx_sr[WORD_W-2:0], rx_bit};
            end
         end
      end
   end

   // pins: enable polarity inverted for an active-low slave enable
   assign ser_tx_clock_pin_out = sclk;
   assign ser_tx_clock_pin_oe = master_role & enable;
   assign tx_frame_sync_pin_out = tx_sync_polarity ? ~fs_act : fs_act;
   assign tx_frame_sync_pin_oe = master_role & enable;
   assign ser_tx_data_pin_out = tx_sr[WORD_W-1];
   assign ser_tx_data_pin_oe = master_role ? m_oe : slv_oe;

   // register bus: address/data capture and responses
   wire wr_ctrl = wr_go & (aw_addr == ADDR_CTRL);
   wire wr_sts = wr_go & (aw_addr == ADDR_STATUS);
   wire wr_ok = (aw_addr == ADDR_CTRL) | wr_tx | (aw_addr == ADDR_STATUS);
   wire busy = (state != SPISC_IDLE) | slv_prev_frame;
   wire [31:0] status = {25'h0, overrun, slave_clk_ok, slave_role, master_role, rx_valid, ~tx_in_ready, busy};
   wire rd_known = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_RXDATA) | (s_axi_araddr == ADDR_STATUS);
   wire [31:0] rd_mux = (s_axi_araddr == ADDR_CTRL) ? ctrl :
      (s_axi_araddr == ADDR_RXDATA) ? {23'h0, rx_valid, rx_data} :
      (s_axi_araddr == ADDR_STATUS) ? status : 32'h0;
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_take) aw_addr <= s_axi_awaddr;
         if (w_take) w_data <= s_axi_wdata;
         aw_held <= (aw_held | aw_take) & ~wr_go;
         w_held <= (w_held | w_take) & ~wr_go;
         if (wr_go) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         s_axi_bvalid <= wr_go | (s_axi_bvalid & ~s_axi_bready);
      end
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (ar_take) s_axi_rdata <= rd_mux;
         if (ar_take) s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
         s_axi_rvalid <= ar_take | (s_axi_rvalid & ~s_axi_rready);
      end
   end
   // control register and overrun flag; a new overrun wins over the clear
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl <= CTRL_RESET;
         overrun <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl <= w_data;
         overrun <= (rx_push & ~rx_in_ready) | (overrun & ~(wr_sts & w_data[STS_OVR]));
      end
   end

   // assertion helpers: cycles since frame start or last clock toggle, and lag length
   logic [CNT_W-1:0] ph_len;
   logic [CNT_W-1:0] lag_seen;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ph_len <= '0;
         lag_seen <= '0;
      end else begin
         ph_len <= (m_lead | m_trail | m_go) ? '0 : CNT_W'(ph_len + 1'b1);
         lag_seen <= (state == SPISC_LAG) ? CNT_W'(lag_seen + 1'b1) : '0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_enable_inv;
      (master_role & tx_sync_polarity) |-> (tx_frame_sync_pin_out == ~fs_act);
   endproperty
   a_enable_inv: assert property (p_enable_inv) else $error("enable not inverted");
   property p_idle_level;
      (state == SPISC_IDLE) |=> (ser_tx_clock_pin_out == $past(tx_clock_polarity)) | fs_act;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("clock not idle between frames");
   property p_low_phase;
      (m_lead & ~tx_clock_polarity & (state == SPISC_RUN) & $stable(ctrl)) |-> (ph_len == low_w - 1'b1);
   endproperty
   a_low_phase: assert property (p_low_phase) else $error("low phase width wrong");
   property p_high_phase;
      (m_trail & ~tx_clock_polarity & $stable(ctrl)) |-> (ph_len == high_w - 1'b1);
   endproperty
   a_high_phase: assert property (p_high_phase) else $error("high phase width wrong");
   property p_lead;
      ((state == SPISC_LEAD) & (cnt == '0) & $stable(ctrl)) |-> (ph_len == lead_len - 1'b1) && fs_act;
   endproperty
   a_lead: assert property (p_lead) else $error("enable lead wrong");
   property p_lag;
      ((state == SPISC_LAG) & (cnt == '0) & $stable(ctrl)) |-> (lag_seen == lag_len - 1'b1) ##1 !fs_act;
   endproperty
   a_lag: assert property (p_lag) else $error("enable lag wrong");
   property p_sample_edge;
      (sample_ev & master_role & mode11 & ~tx_clock_polarity) |=> $rose(ser_tx_clock_pin_out);
   endproperty
   a_sample_edge: assert property (p_sample_edge) else $error("sample not on rising edge");
   property p_slave_oe;
      (slave_role & ~master_role) |-> ##1 (ser_tx_data_pin_oe == $past(s_frame_tx & enable & slave_clk_ok));
   endproperty
   a_slave_oe: assert property (p_slave_oe) else $error("slave data enable wrong");
   property p_master_hiz;
      (master_role & (state == SPISC_IDLE) & ~m_go) |=> ##1 !m_oe || $past(m_go);
   endproperty
   a_master_hiz: assert property (p_master_hiz) else $error("master data not released");
   property p_slave_half;
      slv_oe |-> slave_clk_ok;
   endproperty
   a_slave_half: assert property (p_slave_half) else $error("slave without half-rate clock");
   c_master_frame: cover property ((state == SPISC_LAG) ##1 (state == SPISC_IDLE));
   c_slave_frame: cover property (rx_push & slave_role);
   c_overrun: cover property ($rose(overrun));
   c_tx_full: cover property (!tx_in_ready);
endmodule

// ### verification/spisc_peer.sv
// spisc_peer: spi peer on the far side, passive slave or clock-driving master
// assumes the bench hands it the resolved clock, enable and data levels
`timescale 1ns/10ps
module spisc_peer (
   input wire logic core_clk,
   input wire logic sclk,
   input wire logic en_n,
   input wire logic mosi,
   output logic miso,
   output logic m_sclk,
   output logic m_en_n
);
   logic [7:0] tx = 8'h00;
   logic [7:0] rx = 8'h00;
   logic nr = 1'h0;
   logic last = 1'h0;
   initial begin
      m_sclk = 1'h0;
      m_en_n = 1'h1;
   end
   // capture on rising edges while selected
   always @(posedge sclk) begin
      if (!en_n) begin
         rx <= {rx[6:0], mosi};
         nr <= 1'h1;
      end
   end
   // shift on falling edges, none before the first capture
   always @(negedge sclk) begin
      if (!en_n && nr) begin
         tx <= {tx[6:0], 1'h0};
      end
   end
   always @(posedge en_n) begin
      nr <= 1'h0;
   end
   // a released line shows the inverse of its last bit
   always @(posedge core_clk) begin
      if (!en_n) begin
         last <= tx[7];
      end
   end
   assign miso = en_n ? ~last : tx[7];
   task frame();
      m_en_n <= 1'h0;
      repeat (16) @(posedge core_clk);
      repeat (8) begin
         m_sclk <= 1'h1;
         repeat (8) @(posedge core_clk);
         m_sclk <= 1'h0;
         repeat (8) @(posedge core_clk);
      end
      m_en_n <= 1'h1;
   endtask
endmodule

// ### verification/serial_port_spi_clock_stop_mode_tb_top.sv
// tb top: register bus master, frame timing monitor, master and slave frames
// assumes spisc_top and spisc_peer are compiled before it
`timescale 1ns/10ps
module serial_port_spi_clock_stop_mode_tb_top;
   import spisc_pkg::*;
   typedef struct {logic [1:0] m; logic p; logic [7:0] dv, tx, px; int ld, lg, lo, hi;} spisc_row_t;
   // mode, polarity, divider, bytes, then lead, lag, low and high widths
   spisc_row_t rows[4] = '{'{2'h3, 1'h0, 8'h05, 8'ha5, 8'h3c, 6, 3, 3, 3}, '{2'h3, 1'h0, 8'h06, 8'h81, 8'h7e, 7, 3, 3, 4},
      '{2'h2, 1'h1, 8'h06, 8'h01, 8'h80, 4, 7, 3, 4}, '{2'h2, 1'h1, 8'h07, 8'hff, 8'h00, 4, 8, 4, 4}};
   logic core_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, c, d;
   logic ser_tx_clock_pin_out, ser_tx_clock_pin_oe, tx_frame_sync_pin_out, tx_frame_sync_pin_oe;
   logic ser_tx_data_pin_out, ser_tx_data_pin_oe, ser_rx_data_pin, m_sclk, m_en_n, tgl = 1'h0;
   int errors = 0, checks_done = 0, i, ld, lg, lo, hi, ne;
   // pin levels resolved from the DUT's enables only; a free data line toggles
   wire ser_tx_clock_pin_in = ser_tx_clock_pin_oe ? ser_tx_clock_pin_out : m_sclk;
   wire tx_frame_sync_pin_in = tx_frame_sync_pin_oe ? tx_frame_sync_pin_out : m_en_n;
   wire rx_frame_sync_pin = tx_frame_sync_pin_in;
   wire mosi = ser_tx_data_pin_oe ? ser_tx_data_pin_out : tgl;
   spisc_top spisc_top_inst (.*);
   spisc_peer spisc_peer_inst (.core_clk, .sclk(ser_tx_clock_pin_in), .en_n(tx_frame_sync_pin_in), .mosi,
      .miso(ser_rx_data_pin), .m_sclk, .m_en_n);
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) tgl <= ~tgl;
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // write: address and data offered together, each released when taken
   task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, tb;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      repeat (400) begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb) begin
            s_axi_bready <= 1'h0;
            return;
         end
      end
      errors++;
      print_verdict();
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      logic ta, tv;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      repeat (400) begin
         @(negedge core_clk);
         ta = s_axi_arready;
         tv = s_axi_rvalid;
         v = s_axi_rdata;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tv) begin
            s_axi_rready <= 1'h0;
            return;
         end
      end
      errors++;
      print_verdict();
   endtask
   // measures one frame: lead, lag, last low and high widths, edge count
   task mon();
      int t, lc;
      logic p;
      ld = -1;
      ne = 0;
      t = 0;
      lc = 0;
      repeat (400) if (tx_frame_sync_pin_in) @(negedge core_clk);
      p = ser_tx_clock_pin_in;
      while (!tx_frame_sync_pin_in && t < 400) begin
         @(negedge core_clk);
         t++;
         if (ser_tx_clock_pin_in !== p) begin
            if (ld < 0) ld = t;
            else if (ser_tx_clock_pin_in) lo = t - lc;
            else hi = t - lc;
            lc = t;
            p = ser_tx_clock_pin_in;
            ne++;
         end
      end
      lg = t - lc;
      // no frame seen, or the enable never returned: count it and stop
      if (ld < 0 || tx_frame_sync_pin_in !== 1'h1) begin
         errors++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'h1;
      chk("oe at reset", 32'h0, {ser_tx_clock_pin_oe, tx_frame_sync_pin_oe, ser_tx_data_pin_oe});
      rd(ADDR_CTRL, d);
      chk("ctrl reset", CTRL_RESET, d);
      wr(4'h6, 32'h1, r);
      chk("unmapped resp", RESP_SLVERR, r);
      for (i = 0; i < 4; i++) begin
         c = 32'h0000_00f0 | {8'h00, rows[i].dv, 12'h000, rows[i].p, rows[i].m, 1'h0};
         wr(ADDR_CTRL, c, r);
         spisc_peer_inst.tx = rows[i].px;
         wr(ADDR_TXDATA, {24'h0, rows[i].tx}, r);
         fork
            wr(ADDR_CTRL, c | 32'h1, r);
            mon();
         join
         chk("lead", rows[i].ld, ld);
         chk("lag", rows[i].lg, lg);
         chk("low width", rows[i].lo, lo);
         chk("high width", rows[i].hi, hi);
         chk("edges", 32'h10, ne);
         chk("idle clock", rows[i].p, ser_tx_clock_pin_out);
         chk("idle enable", 32'h1, tx_frame_sync_pin_out);
         chk("data release", 32'h0, ser_tx_data_pin_oe);
         chk("peer byte", rows[i].tx, spisc_peer_inst.rx);
         rd(ADDR_RXDATA, d);
         chk("rx word", {23'h0, 1'h1, rows[i].px}, d);
      end
      rd(ADDR_STATUS, d);
      chk("master role", 32'h1, d[3]);
      // two words queued while stopped, received words left unread
      wr(ADDR_CTRL, c, r);
      spisc_peer_inst.tx = 8'h5a;
      wr(ADDR_TXDATA, 32'h11, r);
      wr(ADDR_TXDATA, 32'h22, r);
      rd(ADDR_STATUS, d);
      chk("tx full", 32'h1, d[1]);
      fork
         wr(ADDR_CTRL, c | 32'h1, r);
         mon();
      join
      mon();
      chk("second byte", 32'h22, spisc_peer_inst.rx);
      rd(ADDR_RXDATA, d);
      chk("rx first", 32'h15a, d);
      rd(ADDR_RXDATA, d);
      chk("rx second", 32'h100, d);
      rd(ADDR_RXDATA, d);
      chk("rx empty", 32'h0, d[8]);
      // slave role: clock and enable come from the peer
      wr(ADDR_CTRL, 32'h0001_0437, r);
      spisc_peer_inst.tx = 8'h96;
      wr(ADDR_TXDATA, 32'h69, r);
      fork
         spisc_peer_inst.frame();
         begin
            repeat (40) @(negedge core_clk);
            chk("slave data oe", 32'h1, ser_tx_data_pin_oe);
            chk("slave clock oe", 32'h0, ser_tx_clock_pin_oe);
         end
      join
      chk("slave sent", 32'h69, spisc_peer_inst.rx);
      rd(ADDR_RXDATA, d);
      chk("slave got", 32'h196, d);
      repeat (20) if (ser_tx_data_pin_oe) @(negedge core_clk);
      chk("slave release", 32'h0, ser_tx_data_pin_oe);
      rd(ADDR_STATUS, d);
      chk("slave status", 32'h3, d[5:4]);
      // three slave frames left unread: the third word finds the buffer full
      repeat (3) begin
         spisc_peer_inst.frame();
         repeat (8) @(posedge core_clk);
      end
      rd(ADDR_STATUS, d);
      chk("overrun", 32'h1, d[6]);
      wr(ADDR_STATUS, 32'h40, r);
      rd(ADDR_STATUS, d);
      chk("overrun clear", 32'h0, d[6]);
      // mid-run reset drops every pin enable and empties the receive buffer
      reset_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'h1;
      chk("oe in reset", 32'h0, {ser_tx_clock_pin_oe, tx_frame_sync_pin_oe, ser_tx_data_pin_oe});
      rd(ADDR_RXDATA, d);
      chk("rx after reset", 32'h0, d);
      print_verdict();
   end
endmodule
